// >>> tw_slave_pkg.sv
// Constants for the two-wire slave transmitter status logic
package tw_slave_pkg;
	localparam int DATA_W = 8;
	localparam int CNT_W = 4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	// Fields of the own_address_register input and of the received address byte
	localparam int ADDR_MSB = 7;
	localparam int ADDR_LSB = 1;
	localparam int GCE_POS = 0;
	localparam int RW_POS = 0;
	localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
	// Status codes
	localparam logic [7:0] ST_OWN_READ = 8'ha8;
	localparam logic [7:0] ST_ARB_READ = 8'hb0;
	localparam logic [7:0] ST_DATA_ACK = 8'hb8;
	localparam logic [7:0] ST_DATA_NACK = 8'hc0;
	localparam logic [7:0] ST_LAST_ACK = 8'hc8;
	localparam logic [7:0] ST_NO_INFO = 8'hf8;
	localparam logic [7:0] ST_BUS_ERROR = 8'h00;
	// Reset values
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam logic BUS_FREE_RESET = 1'b1;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_AACK = 3'b010,
		S_HOLD = 3'b011,
		S_TX = 3'b100,
		S_TACK = 3'b101,
		S_BERR = 3'b110
	} slave_state_t;
endpackage

// >>> link_bit_sample.sv
// Samples the data line on each rising edge of the bus clock
`timescale 1ns/10ps
module link_bit_sample (
	input wire logic scl_clk_in,
	input wire logic sda_in,
	output logic bit_out
);
	logic bit_r;

	always_ff @(posedge scl_clk_in) begin
		bit_r <= sda_in;
	end

	assign bit_out = bit_r;
endmodule

// >>> two_wire_slave_tx_status.sv
// Two-wire slave transmitter with status codes and bus error handling
// How it works
// - Own address read acknowledged: flag, code a8
// - Ack enable zero: byte sent as last
// - Ack enable one: byte sent expecting acknowledge
// - Lost arbitration yet read-addressed: code b0
// - Byte acknowledged: flag, code b8
// - Byte not acknowledged: flag, code c0
// - Last byte still acknowledged: flag, code c8
// - Resume, ack enable zero: ignore all addresses
// - Resume, ack enable one: recognise addresses
// - Start request on resume: start when free
// - Flag clear: status reads f8
// - Misplaced start or stop: bus error 00
// - Bus error sets the done flag
// - Recovery: not addressed, stop bit cleared
// - Recovery releases lines, sends no stop
// - Repeated start turns write into read
// - Address register: seven address bits, gce
// - Ack enable zero hides own address
`timescale 1ns/10ps
module two_wire_slave_tx_status (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [7:0] own_address_register_in,
	input wire logic master_addr_phase_in,
	input wire logic data_wr_in,
	input wire logic [7:0] data_in,
	input wire logic ctrl_wr_in,
	input wire logic transfer_done_clear_in,
	input wire logic ack_enable_bit_in,
	input wire logic start_request_bit_in,
	input wire logic stop_request_bit_in,
	output logic [7:0] status_code_register_out,
	output logic [7:0] shift_data_register_out,
	output logic transfer_done_flag_out,
	output logic ack_enable_bit_out,
	output logic start_request_bit_out,
	output logic stop_request_bit_out,
	output logic start_issue_out,
	output logic bus_free_out
);
	logic link_bit;
	logic scl_m_r, scl_s_r, scl_p_r;
	logic sda_m_r, sda_s_r, sda_p_r;
	logic bit_m_r, bit_s_r;
	logic scl_rise, scl_fall, start_seen, stop_seen;
	tw_slave_pkg::slave_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] data_r, data_nxt;
	logic [7:0] code_r, code_nxt;
	logic [7:0] status_r, status_nxt;
	logic done_r, done_nxt;
	logic ack_en_r, ack_en_nxt;
	logic start_r, start_nxt;
	logic stop_r, stop_nxt;
	logic last_r, last_nxt;
	logic ack_r, ack_nxt;
	logic arb_r, arb_nxt;
	logic free_r, free_nxt;
	logic issue_r, issue_nxt;
	logic sda_drv_r, sda_drv_nxt;
	logic armed_r, armed_nxt;
	logic resume;
	logic own_match, gc_match;

	link_bit_sample u_link (
		.scl_clk_in(scl_in),
		.sda_in(sda_in),
		.bit_out(link_bit)
	);

	// Two-flop synchronisers for the bus lines and the link sample
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_p_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_p_r <= 1'b1;
			bit_m_r <= 1'b1;
			bit_s_r <= 1'b1;
		end else begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_p_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_p_r <= sda_s_r;
			bit_m_r <= link_bit;
			bit_s_r <= bit_m_r;
		end
	end

	assign scl_rise = scl_s_r && !scl_p_r;
	assign scl_fall = !scl_s_r && scl_p_r;
	assign start_seen = scl_s_r && scl_p_r && sda_p_r && !sda_s_r;
	assign stop_seen = scl_s_r && scl_p_r && !sda_p_r && sda_s_r;
	assign resume = ctrl_wr_in && transfer_done_clear_in;

	// Address compare; recognition needs ack enable
	always_comb begin
		own_match = ack_en_r && (shift_r[7:1] ==
			own_address_register_in[tw_slave_pkg::ADDR_MSB:
			tw_slave_pkg::ADDR_LSB]);
		gc_match = ack_en_r &&
			own_address_register_in[tw_slave_pkg::GCE_POS] &&
			(shift_r[7:1] == tw_slave_pkg::GENERAL_CALL_ADDRESS);
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		data_nxt = data_r;
		code_nxt = code_r;
		done_nxt = done_r && !resume;
		ack_en_nxt = ack_en_r;
		start_nxt = start_r;
		stop_nxt = stop_r;
		last_nxt = last_r;
		ack_nxt = ack_r;
		arb_nxt = arb_r;
		free_nxt = free_r;
		issue_nxt = 1'b0;
		sda_drv_nxt = sda_drv_r;
		armed_nxt = armed_r;

		// Software writes
		if (data_wr_in) begin
			data_nxt = data_in;
		end
		if (ctrl_wr_in) begin
			ack_en_nxt = ack_enable_bit_in;
			start_nxt = start_request_bit_in;
			stop_nxt = stop_request_bit_in;
		end

		// Bus free tracking; after a repeated start the bus stays owned
		if (stop_seen) begin
			free_nxt = 1'b1;
		end else if (start_seen) begin
			free_nxt = 1'b0;
		end

		case (state_r)
			tw_slave_pkg::S_IDLE: begin
				sda_drv_nxt = 1'b0;
				if (start_seen) begin
					state_nxt = tw_slave_pkg::S_ADDR;
					cnt_nxt = tw_slave_pkg::CNT_RESET;
					arb_nxt = master_addr_phase_in;
					armed_nxt = 1'b0;
				end else if (start_r && free_r && !done_r) begin
					issue_nxt = 1'b1;
					start_nxt = 1'b0;
				end
			end
			tw_slave_pkg::S_ADDR: begin
				arb_nxt = arb_r || master_addr_phase_in;
				if (start_seen && cnt_r == tw_slave_pkg::CNT_RESET) begin
					cnt_nxt = tw_slave_pkg::CNT_RESET;
					armed_nxt = 1'b0;
				end else if (start_seen || stop_seen) begin
					state_nxt = tw_slave_pkg::S_BERR;
				end else if (scl_fall) begin
					// The fall that follows a start carries no bit
					armed_nxt = 1'b1;
					if (armed_r) begin
						shift_nxt = {shift_r[6:0], bit_s_r};
						cnt_nxt = cnt_r + 4'h1;
					end
				end else if (cnt_r == tw_slave_pkg::BITS_PER_BYTE) begin
					if (own_match && !gc_match &&
						shift_r[tw_slave_pkg::RW_POS]) begin
						state_nxt = tw_slave_pkg::S_AACK;
						sda_drv_nxt = 1'b1;
					end else begin
						// Write direction and general call go elsewhere
						state_nxt = tw_slave_pkg::S_IDLE;
					end
					cnt_nxt = tw_slave_pkg::CNT_RESET;
				end
			end
			tw_slave_pkg::S_AACK: begin
				if (start_seen || stop_seen) begin
					state_nxt = tw_slave_pkg::S_BERR;
					sda_drv_nxt = 1'b0;
				end else if (scl_fall) begin
					sda_drv_nxt = 1'b0;
					done_nxt = 1'b1;
					state_nxt = tw_slave_pkg::S_HOLD;
					if (arb_r) begin
						code_nxt = tw_slave_pkg::ST_ARB_READ;
					end else begin
						code_nxt = tw_slave_pkg::ST_OWN_READ;
					end
				end
			end
			tw_slave_pkg::S_HOLD: begin
				if (resume) begin
					if (code_r == tw_slave_pkg::ST_DATA_NACK ||
						code_r == tw_slave_pkg::ST_LAST_ACK) begin
						// Not addressed; ack enable picks recognition
						state_nxt = tw_slave_pkg::S_IDLE;
					end else begin
						shift_nxt = data_nxt;
						last_nxt = !ack_enable_bit_in;
						cnt_nxt = tw_slave_pkg::CNT_RESET;
						sda_drv_nxt = !data_nxt[7];
						state_nxt = tw_slave_pkg::S_TX;
					end
				end
			end
			tw_slave_pkg::S_TX: begin
				if (start_seen || stop_seen) begin
					state_nxt = tw_slave_pkg::S_BERR;
					sda_drv_nxt = 1'b0;
				end else if (scl_fall) begin
					if (cnt_r == tw_slave_pkg::LAST_BIT) begin
						sda_drv_nxt = 1'b0;
						state_nxt = tw_slave_pkg::S_TACK;
					end else begin
						shift_nxt = {shift_r[6:0], 1'b1};
						sda_drv_nxt = !shift_r[6];
						cnt_nxt = cnt_r + 4'h1;
					end
				end
			end
			tw_slave_pkg::S_TACK: begin
				if (start_seen || stop_seen) begin
					state_nxt = tw_slave_pkg::S_BERR;
				end else if (scl_rise) begin
					ack_nxt = !sda_s_r;
				end else if (scl_fall) begin
					done_nxt = 1'b1;
					state_nxt = tw_slave_pkg::S_HOLD;
					if (!ack_r) begin
						code_nxt = tw_slave_pkg::ST_DATA_NACK;
					end else if (last_r) begin
						code_nxt = tw_slave_pkg::ST_LAST_ACK;
					end else begin
						code_nxt = tw_slave_pkg::ST_DATA_ACK;
					end
				end
			end
			tw_slave_pkg::S_BERR: begin
				sda_drv_nxt = 1'b0;
				if (resume && stop_request_bit_in) begin
					state_nxt = tw_slave_pkg::S_IDLE;
					stop_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = tw_slave_pkg::S_IDLE;
			end
		endcase

		// Error entry sets the flag; the set wins over a clear
		if (state_nxt == tw_slave_pkg::S_BERR &&
			state_r != tw_slave_pkg::S_BERR) begin
			code_nxt = tw_slave_pkg::ST_BUS_ERROR;
			done_nxt = 1'b1;
		end

		if (done_nxt) begin
			status_nxt = code_nxt;
		end else begin
			status_nxt = tw_slave_pkg::ST_NO_INFO;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_r <= tw_slave_pkg::S_IDLE;
			cnt_r <= tw_slave_pkg::CNT_RESET;
			shift_r <= tw_slave_pkg::DATA_RESET;
			data_r <= tw_slave_pkg::DATA_RESET;
			code_r <= tw_slave_pkg::ST_NO_INFO;
			status_r <= tw_slave_pkg::ST_NO_INFO;
			done_r <= 1'b0;
			ack_en_r <= 1'b0;
			start_r <= 1'b0;
			stop_r <= 1'b0;
			last_r <= 1'b0;
			ack_r <= 1'b0;
			arb_r <= 1'b0;
			free_r <= tw_slave_pkg::BUS_FREE_RESET;
			issue_r <= 1'b0;
			sda_drv_r <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			data_r <= data_nxt;
			code_r <= code_nxt;
			status_r <= status_nxt;
			done_r <= done_nxt;
			ack_en_r <= ack_en_nxt;
			start_r <= start_nxt;
			stop_r <= stop_nxt;
			last_r <= last_nxt;
			ack_r <= ack_nxt;
			arb_r <= arb_nxt;
			free_r <= free_nxt;
			issue_r <= issue_nxt;
			sda_drv_r <= sda_drv_nxt;
			armed_r <= armed_nxt;
		end
	end

	// Lines only ever pull low; clock held in the hold state while waiting on software
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_out = done_r &&
		(state_r == tw_slave_pkg::S_HOLD);
	assign sda_oe_out = sda_drv_r;
	assign status_code_register_out = status_r;
	assign shift_data_register_out = data_r;
	assign transfer_done_flag_out = done_r;
	assign ack_enable_bit_out = ack_en_r;
	assign start_request_bit_out = start_r;
	assign stop_request_bit_out = stop_r;
	assign start_issue_out = issue_r;
	assign bus_free_out = free_r;
endmodule

// >>> tw_slave_properties.sv
// Concurrent checks on the slave transmitter ports
`timescale 1ns/10ps
module tw_slave_properties (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scl_oe_out,
	input wire logic ctrl_wr_in,
	input wire logic transfer_done_clear_in,
	input wire logic stop_request_bit_in,
	input wire logic [7:0] status_code_register_out,
	input wire logic transfer_done_flag_out,
	input wire logic start_request_bit_out,
	input wire logic stop_request_bit_out,
	input wire logic start_issue_out,
	input wire logic bus_free_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	chk_idle_code: assert property (
		!transfer_done_flag_out |->
		status_code_register_out == tw_slave_pkg::ST_NO_INFO)
		else $error("status not idle code with flag clear");
	chk_flag_code: assert property (
		$rose(transfer_done_flag_out) |->
		status_code_register_out != tw_slave_pkg::ST_NO_INFO)
		else $error("flag set without a status code");
	chk_flag_hold: assert property (
		transfer_done_flag_out && !(ctrl_wr_in && transfer_done_clear_in)
		|=> transfer_done_flag_out)
		else $error("flag dropped without a clear");
	chk_clock_stretch: assert property (
		$past(transfer_done_flag_out) && transfer_done_flag_out &&
		(status_code_register_out == tw_slave_pkg::ST_OWN_READ ||
		status_code_register_out == tw_slave_pkg::ST_ARB_READ ||
		status_code_register_out == tw_slave_pkg::ST_DATA_ACK) |-> scl_oe_out)
		else $error("clock not held while addressed and flagged");
	chk_error_release: assert property (
		transfer_done_flag_out &&
		status_code_register_out == tw_slave_pkg::ST_BUS_ERROR |-> !scl_oe_out)
		else $error("clock held during bus error");
	chk_error_recover: assert property (
		ctrl_wr_in && transfer_done_clear_in && stop_request_bit_in &&
		transfer_done_flag_out &&
		status_code_register_out == tw_slave_pkg::ST_BUS_ERROR
		|=> !stop_request_bit_out && !transfer_done_flag_out)
		else $error("bus error recovery failed");
	chk_issue_cause: assert property (
		start_issue_out |-> $past(start_request_bit_out) && $past(bus_free_out))
		else $error("start issued without request or free bus");
	chk_issue_once: assert property (
		start_issue_out |=> !start_issue_out && !start_request_bit_out)
		else $error("start issue not a single pulse");
endmodule

// >>> tw_mst.sv
// Bus master receiver model driving the two-wire lines
`timescale 1ns/10ps
module tw_mst (
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe_out,
	output logic sda_oe_out
);
	localparam time Q = 240ns;
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end
	task automatic clk_bit(input logic b, output logic s);
		int n;
		n = 0;
		#Q sda_oe_out = !b;
		#Q scl_oe_out = 1'b0;
		while (!scl_in && n < 100) begin
			#Q n++;
		end
		#Q s = (n < 100) ? sda_in : 1'bx;
		#Q scl_oe_out = 1'b1;
	endtask
	task automatic start_c();
		#Q sda_oe_out = 1'b0;
		#Q scl_oe_out = 1'b0;
		#Q sda_oe_out = 1'b1;
		#Q scl_oe_out = 1'b1;
	endtask
	task automatic stop_c();
		#Q sda_oe_out = 1'b1;
		#Q scl_oe_out = 1'b0;
		#Q sda_oe_out = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] w, input logic a,
		output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(w[i], r[i]);
		end
		clk_bit(a, k);
	endtask
endmodule

// >>> two_wire_slave_tx_status_tb_top.sv
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/10ps
module two_wire_slave_tx_status_tb_top;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic scl_oe, sda_oe, m_scl, m_sda, scl_w, sda_w, ack, arb, dwr, cwr;
	logic clr, ae, sa, so, flag, ae_o, sa_o, so_o, issue, free;
	logic [7:0] status, sd, din, rb;
	int fails = 0;
	int num_checks = 0;
	assign scl_w = !(scl_oe | m_scl);
	assign sda_w = !(sda_oe | m_sda);
	initial begin
		forever #20 clk_in = !clk_in;
	end
	two_wire_slave_tx_status two_wire_slave_tx_status_i (
		.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_w), .scl_out(),
		.scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe),
		.own_address_register_in(8'hb5), .master_addr_phase_in(arb),
		.data_wr_in(dwr), .data_in(din), .ctrl_wr_in(cwr),
		.transfer_done_clear_in(clr), .ack_enable_bit_in(ae),
		.start_request_bit_in(sa), .stop_request_bit_in(so),
		.status_code_register_out(status), .shift_data_register_out(sd),
		.transfer_done_flag_out(flag), .ack_enable_bit_out(ae_o),
		.start_request_bit_out(sa_o), .stop_request_bit_out(so_o),
		.start_issue_out(issue), .bus_free_out(free));
	tw_mst tw_mst_i (.scl_in(scl_w), .sda_in(sda_w),
		.scl_oe_out(m_scl), .sda_oe_out(m_sda));
	task automatic close_out();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic ctl(input logic ld, input logic [7:0] d, input logic [3:0] c);
		@(posedge clk_in);
		dwr <= ld;
		din <= d;
		cwr <= 1'b1;
		{clr, ae, sa, so} <= c;
		@(posedge clk_in);
		dwr <= 1'b0;
		cwr <= 1'b0;
		@(negedge clk_in);
	endtask
	task automatic wflag(input logic [7:0] e);
		int n;
		n = 0;
		while (flag !== 1'b1 && n < 300) begin
			@(negedge clk_in);
			n++;
		end
		cmp(status, e);
		if (n == 300) begin
			fails++;
			close_out();
		end
	endtask
	task automatic t_read();
		ctl(1'b0, 8'h00, 4'b0100);
		tw_mst_i.start_c();
		tw_mst_i.xfer(8'hb5, 1'b1, rb, ack);
		cmp({7'h00, ack}, 8'h00);
		wflag(8'ha8);
		cmp({7'h00, scl_oe}, 8'h01);
		ctl(1'b1, 8'ha5, 4'b1100);
		cmp(sd, 8'ha5);
		tw_mst_i.xfer(8'hff, 1'b0, rb, ack);
		cmp(rb, 8'ha5);
		wflag(8'hb8);
		ctl(1'b1, 8'h3c, 4'b1000);
		tw_mst_i.xfer(8'hff, 1'b1, rb, ack);
		cmp(rb, 8'h3c);
		wflag(8'hc0);
		ctl(1'b0, 8'h00, 4'b1100);
		cmp(status, 8'hf8);
		tw_mst_i.stop_c();
	endtask
	task automatic t_last();
		int n;
		n = 0;
		tw_mst_i.start_c();
		tw_mst_i.xfer(8'hb5, 1'b1, rb, ack);
		wflag(8'ha8);
		ctl(1'b1, 8'h81, 4'b1000);
		tw_mst_i.xfer(8'hff, 1'b0, rb, ack);
		cmp(rb, 8'h81);
		wflag(8'hc8);
		ctl(1'b0, 8'h00, 4'b1010);
		cmp({6'h00, sa_o, free}, 8'h02);
		tw_mst_i.xfer(8'hff, 1'b1, rb, ack);
		cmp(rb, 8'hff);
		tw_mst_i.stop_c();
		while (issue !== 1'b1 && n < 50) begin
			@(negedge clk_in);
			n++;
		end
		cmp({7'h00, issue}, 8'h01);
		cmp({6'h00, sa_o, free}, 8'h01);
		if (n == 50) begin
			fails++;
			close_out();
		end
		tw_mst_i.start_c();
		tw_mst_i.xfer(8'hb5, 1'b1, rb, ack);
		cmp({7'h00, ack}, 8'h01);
		tw_mst_i.stop_c();
	endtask
	task automatic t_addr();
		ctl(1'b0, 8'h00, 4'b0100);
		tw_mst_i.start_c();
		tw_mst_i.xfer(8'hb7, 1'b1, rb, ack);
		cmp({7'h00, ack}, 8'h01);
		@(posedge clk_in);
		arb <= 1'b1;
		tw_mst_i.start_c();
		tw_mst_i.xfer(8'hb5, 1'b1, rb, ack);
		cmp({7'h00, ack}, 8'h00);
		wflag(8'hb0);
		@(posedge clk_in);
		arb <= 1'b0;
		ctl(1'b1, 8'h00, 4'b1000);
		tw_mst_i.xfer(8'hff, 1'b1, rb, ack);
		cmp(rb, 8'h00);
		wflag(8'hc0);
		ctl(1'b0, 8'h00, 4'b1100);
		tw_mst_i.stop_c();
	endtask
	task automatic t_berr();
		logic s;
		tw_mst_i.start_c();
		for (int i = 0; i < 3; i++) begin
			tw_mst_i.clk_bit(1'b1, s);
		end
		tw_mst_i.start_c();
		wflag(8'h00);
		cmp({6'h00, scl_oe, sda_oe}, 8'h00);
		ctl(1'b0, 8'h00, 4'b1101);
		cmp({5'h00, flag, ae_o, so_o}, 8'h02);
		cmp(status, 8'hf8);
		tw_mst_i.stop_c();
	endtask
	initial begin
		{arb, dwr, cwr, clr, ae, sa, so} = 7'h00;
		din = 8'h00;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (3) @(negedge clk_in);
		cmp(status, 8'hf8);
		t_read();
		t_last();
		t_addr();
		t_berr();
		close_out();
	end
endmodule
bind two_wire_slave_tx_status tw_slave_properties props_i (
	.clk_in(clk_in), .rst_in(rst_in), .scl_oe_out(scl_oe_out),
	.ctrl_wr_in(ctrl_wr_in), .transfer_done_clear_in(transfer_done_clear_in),
	.stop_request_bit_in(stop_request_bit_in),
	.status_code_register_out(status_code_register_out),
	.transfer_done_flag_out(transfer_done_flag_out),
	.start_request_bit_out(start_request_bit_out),
	.stop_request_bit_out(stop_request_bit_out),
	.start_issue_out(start_issue_out), .bus_free_out(bus_free_out));
